// *** swmd_pkg.sv ***
// constants and carrier types for the signal word mux/demux block
// Behaviour
// - sixteen selectable one-bit inputs are packed into one multiplexer output word
// - the multiplexer word may feed the system bus or fieldbus transmit word
// - write-index selector takes 0 to 33 and resets to 1
// - write-index 0 updates every input index in both stored copies
// - write-index 0 to 16 stores non-volatile; 1 to 16 address one index
// - 17 to 33 write RAM only; power-up reloads RAM from non-volatile copy
// - read-index selector 0 to 33, default 1, chooses which selection reads back
// - a selection written at index 0 applies to all other indices
// - demultiplexer splits one chosen word into sixteen output bits 0 to 15
// - demultiplexer source: zero, received, remote, fieldbus, status or multiplexer word
package swmd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int SEL_W = 10;
  localparam int IDX_W = 6;
  localparam int SLOT_W = 4;
  localparam int NUM_INPUTS = 16;
  localparam int NUM_SIGNALS = 1024;
  localparam int NUM_RXPDO = 24;
  localparam int NUM_FB_OUT = 4;

  localparam logic [ADDR_W-1:0] OFS_WR_INDEX = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RD_INDEX = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MUX_INPUT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_UNPACK_SRC = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MUX_WORD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_UNPACK_WORD = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TX_ROUTE = 8'h18;

  localparam logic [IDX_W-1:0] IDX_ALL_NV = 6'h00;
  localparam logic [IDX_W-1:0] IDX_DEFAULT = 6'h01;
  localparam logic [IDX_W-1:0] IDX_LAST_NV = 6'h10;
  localparam logic [IDX_W-1:0] IDX_ALL_RAM = 6'h11;
  localparam logic [IDX_W-1:0] IDX_RAM_BASE = 6'h12;
  localparam logic [IDX_W-1:0] IDX_MAX = 6'h21;

  localparam logic [SEL_W-1:0] SEL_OFF = 10'h007;
  localparam logic [SEL_W-1:0] SRC_ZERO = 10'h009;
  localparam logic [SEL_W-1:0] SRC_RXPDO_FIRST = 10'h2c0;
  localparam logic [SEL_W-1:0] SRC_RXPDO_LAST = 10'h2d7;
  localparam logic [SEL_W-1:0] SRC_REMOTE_CTRL = 10'h2e4;
  localparam logic [SEL_W-1:0] SRC_REMOTE_STATE = 10'h2e5;
  localparam logic [SEL_W-1:0] SRC_FB_OUT_FIRST = 10'h2f2;
  localparam logic [SEL_W-1:0] SRC_FB_OUT_LAST = 10'h2f5;
  localparam logic [SEL_W-1:0] SRC_CTRL_STATUS = 10'h384;
  localparam logic [SEL_W-1:0] SRC_MUX_OUT = 10'h39f;

  localparam int ROUTE_SYSBUS_BIT = 0;
  localparam int ROUTE_FIELDBUS_BIT = 1;
  localparam logic [1:0] ROUTE_RESET = 2'h0;

  typedef struct packed {
    logic [NUM_RXPDO-1:0][WORD_W-1:0] rxPdo;
    logic [WORD_W-1:0] remoteCtrl;
    logic [WORD_W-1:0] remoteState;
    logic [NUM_FB_OUT-1:0][WORD_W-1:0] fieldbusOutWord;
    logic [WORD_W-1:0] ctrlStatus;
  } swmd_rx_s;

  typedef struct packed {
    logic allSlots;
    logic toNv;
    logic [SLOT_W-1:0] slot;
  } swmd_slot_s;

endpackage

// *** swmd_top.sv ***
// signal word multiplexer/demultiplexer with indexed selection storage
`timescale 1ns/1ps
`default_nettype none
module swmd_top (
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  input  wire logic [swmd_pkg::ADDR_W-1:0]       regAddr,
  input  wire logic [swmd_pkg::DATA_W-1:0]       regWrData,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  output logic      [swmd_pkg::DATA_W-1:0]       regRdData,
  input  wire logic                              powerRestore,
  input  wire logic [swmd_pkg::NUM_SIGNALS-1:0]  logicSignals,
  input  wire swmd_pkg::swmd_rx_s                rxWords,
  output logic      [swmd_pkg::WORD_W-1:0]       muxWord,
  output logic      [swmd_pkg::WORD_W-1:0]       sysBusTxWord,
  output logic      [swmd_pkg::WORD_W-1:0]       fieldbusInWord,
  output logic      [swmd_pkg::WORD_W-1:0]       unpackedBits
);

  // index decode shared by the write and read paths
  function automatic swmd_pkg::swmd_slot_s decodeIndex(
    input logic [swmd_pkg::IDX_W-1:0] idx
  );
    swmd_pkg::swmd_slot_s s;
    s.allSlots = (idx == swmd_pkg::IDX_ALL_NV) || (idx == swmd_pkg::IDX_ALL_RAM);
    s.toNv = (idx <= swmd_pkg::IDX_LAST_NV);
    if (idx >= swmd_pkg::IDX_RAM_BASE) begin
      s.slot = swmd_pkg::SLOT_W'(idx - swmd_pkg::IDX_RAM_BASE);
    end else if (idx == swmd_pkg::IDX_ALL_NV || idx == swmd_pkg::IDX_ALL_RAM) begin
      s.slot = '0;
    end else begin
      s.slot = swmd_pkg::SLOT_W'(idx - swmd_pkg::IDX_DEFAULT);
    end
    return s;
  endfunction

  function automatic logic srcValid(input logic [swmd_pkg::SEL_W-1:0] c);
    return (c == swmd_pkg::SRC_ZERO)
        || (c >= swmd_pkg::SRC_RXPDO_FIRST && c <= swmd_pkg::SRC_RXPDO_LAST)
        || (c == swmd_pkg::SRC_REMOTE_CTRL) || (c == swmd_pkg::SRC_REMOTE_STATE)
        || (c >= swmd_pkg::SRC_FB_OUT_FIRST && c <= swmd_pkg::SRC_FB_OUT_LAST)
        || (c == swmd_pkg::SRC_CTRL_STATUS) || (c == swmd_pkg::SRC_MUX_OUT);
  endfunction

  // element-select widths for the received word arrays
  localparam int RXPDO_IDX_W = $clog2(swmd_pkg::NUM_RXPDO);
  localparam int FB_OUT_IDX_W = $clog2(swmd_pkg::NUM_FB_OUT);

  logic [swmd_pkg::IDX_W-1:0]                          wrIndex_reg;
  logic [swmd_pkg::IDX_W-1:0]                          rdIndex_reg;
  logic [swmd_pkg::NUM_INPUTS-1:0][swmd_pkg::SEL_W-1:0] nvSel_reg;
  logic [swmd_pkg::NUM_INPUTS-1:0][swmd_pkg::SEL_W-1:0] ramSel_reg;
  logic [swmd_pkg::SEL_W-1:0]                          unpackWordSourceSelect_reg;
  logic [1:0]                                          txRoute_reg;
  logic [swmd_pkg::WORD_W-1:0]                         muxWord_next;
  logic [swmd_pkg::WORD_W-1:0]                         srcWord;
  logic [swmd_pkg::SEL_W-1:0]                          rdSel;
  logic [swmd_pkg::DATA_W-1:0]                         rdData_next;
  logic                                                wrHit;
  logic                                                selWr;
  swmd_pkg::swmd_slot_s                                wrSlot;
  swmd_pkg::swmd_slot_s                                rdSlot;
  logic [swmd_pkg::SEL_W-1:0]                          newSel;

  assign wrSlot = decodeIndex(wrIndex_reg);
  assign rdSlot = decodeIndex(rdIndex_reg);
  assign selWr = regWr && (regAddr == swmd_pkg::OFS_MUX_INPUT);
  assign newSel = regWrData[swmd_pkg::SEL_W-1:0];
  assign wrHit = regWr;

  // out-of-range index writes are dropped so the selector never leaves 0..33
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrIndex_reg <= swmd_pkg::IDX_DEFAULT;
    end else if (wrHit && regAddr == swmd_pkg::OFS_WR_INDEX &&
                 regWrData[swmd_pkg::IDX_W-1:0] <= swmd_pkg::IDX_MAX &&
                 regWrData[swmd_pkg::DATA_W-1:swmd_pkg::IDX_W] == '0) begin
      wrIndex_reg <= regWrData[swmd_pkg::IDX_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdIndex_reg <= swmd_pkg::IDX_DEFAULT;
    end else if (wrHit && regAddr == swmd_pkg::OFS_RD_INDEX &&
                 regWrData[swmd_pkg::IDX_W-1:0] <= swmd_pkg::IDX_MAX &&
                 regWrData[swmd_pkg::DATA_W-1:swmd_pkg::IDX_W] == '0) begin
      rdIndex_reg <= regWrData[swmd_pkg::IDX_W-1:0];
    end
  end

  // persistent copy: only a factory reset clears it, power restore leaves it alone
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nvSel_reg <= {swmd_pkg::NUM_INPUTS{swmd_pkg::SEL_OFF}};
    end else if (selWr && wrSlot.toNv) begin
      if (wrSlot.allSlots) begin
        nvSel_reg <= {swmd_pkg::NUM_INPUTS{newSel}};
      end else begin
        nvSel_reg[wrSlot.slot] <= newSel;
      end
    end
  end

  // live copy: a write racing a power restore wins, it is the newer intent
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ramSel_reg <= {swmd_pkg::NUM_INPUTS{swmd_pkg::SEL_OFF}};
    end else if (selWr) begin
      if (wrSlot.allSlots) begin
        ramSel_reg <= {swmd_pkg::NUM_INPUTS{newSel}};
      end else begin
        ramSel_reg[wrSlot.slot] <= newSel;
      end
    end else if (powerRestore) begin
      ramSel_reg <= nvSel_reg;
    end
  end

  generate
    for (genvar n = 0; n < swmd_pkg::NUM_INPUTS; n++) begin : g_pack
      assign muxWord_next[n] = logicSignals[ramSel_reg[n]];
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      muxWord <= '0;
    end else begin
      muxWord <= muxWord_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txRoute_reg <= swmd_pkg::ROUTE_RESET;
    end else if (wrHit && regAddr == swmd_pkg::OFS_TX_ROUTE) begin
      txRoute_reg <= regWrData[1:0];
    end
  end

  // an unrouted transmit word idles at zero rather than holding stale data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sysBusTxWord <= '0;
      fieldbusInWord <= '0;
    end else begin
      sysBusTxWord <= txRoute_reg[swmd_pkg::ROUTE_SYSBUS_BIT] ? muxWord : '0;
      fieldbusInWord <= txRoute_reg[swmd_pkg::ROUTE_FIELDBUS_BIT] ? muxWord : '0;
    end
  end

  // unlisted source codes are refused so the select always names a real word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unpackWordSourceSelect_reg <= swmd_pkg::SRC_ZERO;
    end else if (wrHit && regAddr == swmd_pkg::OFS_UNPACK_SRC &&
                 regWrData[swmd_pkg::DATA_W-1:swmd_pkg::SEL_W] == '0 &&
                 srcValid(regWrData[swmd_pkg::SEL_W-1:0])) begin
      unpackWordSourceSelect_reg <= regWrData[swmd_pkg::SEL_W-1:0];
    end
  end

  always_comb begin
    srcWord = '0;
    if (unpackWordSourceSelect_reg >= swmd_pkg::SRC_RXPDO_FIRST &&
        unpackWordSourceSelect_reg <= swmd_pkg::SRC_RXPDO_LAST) begin
      srcWord = rxWords.rxPdo[RXPDO_IDX_W'(unpackWordSourceSelect_reg - swmd_pkg::SRC_RXPDO_FIRST)];
    end else if (unpackWordSourceSelect_reg >= swmd_pkg::SRC_FB_OUT_FIRST &&
                 unpackWordSourceSelect_reg <= swmd_pkg::SRC_FB_OUT_LAST) begin
      srcWord = rxWords.fieldbusOutWord[FB_OUT_IDX_W'(unpackWordSourceSelect_reg - swmd_pkg::SRC_FB_OUT_FIRST)];
    end else begin
      case (unpackWordSourceSelect_reg)
        swmd_pkg::SRC_REMOTE_CTRL:  srcWord = rxWords.remoteCtrl;
        swmd_pkg::SRC_REMOTE_STATE: srcWord = rxWords.remoteState;
        swmd_pkg::SRC_CTRL_STATUS:  srcWord = rxWords.ctrlStatus;
        swmd_pkg::SRC_MUX_OUT:      srcWord = muxWord;
        default:                    srcWord = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unpackedBits <= '0;
    end else begin
      unpackedBits <= srcWord;
    end
  end

  // indices 0..16 show the persistent copy, 17..33 the live one
  assign rdSel = rdSlot.toNv ? nvSel_reg[rdSlot.slot] : ramSel_reg[rdSlot.slot];

  always_comb begin
    rdData_next = '0;
    case (regAddr)
      swmd_pkg::OFS_WR_INDEX:    rdData_next = swmd_pkg::DATA_W'(wrIndex_reg);
      swmd_pkg::OFS_RD_INDEX:    rdData_next = swmd_pkg::DATA_W'(rdIndex_reg);
      swmd_pkg::OFS_MUX_INPUT:   rdData_next = swmd_pkg::DATA_W'(rdSel);
      swmd_pkg::OFS_UNPACK_SRC:  rdData_next = swmd_pkg::DATA_W'(unpackWordSourceSelect_reg);
      swmd_pkg::OFS_MUX_WORD:    rdData_next = swmd_pkg::DATA_W'(muxWord);
      swmd_pkg::OFS_UNPACK_WORD: rdData_next = swmd_pkg::DATA_W'(unpackedBits);
      swmd_pkg::OFS_TX_ROUTE:    rdData_next = swmd_pkg::DATA_W'(txRoute_reg);
      default:                   rdData_next = '0;
    endcase
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRd) begin
      regRdData <= rdData_next;
    end else begin
      regRdData <= '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence selWriteAll;
    selWr && wrIndex_reg == swmd_pkg::IDX_ALL_NV;
  endsequence

  sequence selWriteRamOnly;
    selWr && wrIndex_reg >= swmd_pkg::IDX_ALL_RAM;
  endsequence

  sequence srcIsMux;
    (unpackWordSourceSelect_reg == swmd_pkg::SRC_MUX_OUT) [*2];
  endsequence

  pack_bit_map_a: assert property (
    ##1 muxWord[0] == $past(logicSignals[ramSel_reg[0]]) &&
        muxWord[15] == $past(logicSignals[ramSel_reg[15]]))
    else $error("packed word bit does not follow its selected input");

  tx_route_a: assert property (
    txRoute_reg[swmd_pkg::ROUTE_SYSBUS_BIT] |=> sysBusTxWord == $past(muxWord))
    else $error("system bus transmit word is not the packed word");

  wr_index_range_a: assert property (
    wrIndex_reg <= swmd_pkg::IDX_MAX)
    else $error("write index left its range");

  all_write_a: assert property (
    selWriteAll |=> nvSel_reg[15] == $past(newSel) && ramSel_reg[0] == $past(newSel) &&
                    nvSel_reg[0] == $past(newSel))
    else $error("index 0 write did not reach every slot");

  nv_single_a: assert property (
    selWr && wrIndex_reg == swmd_pkg::IDX_DEFAULT |=> nvSel_reg[0] == $past(newSel)
      && $stable(nvSel_reg[1]))
    else $error("single persistent slot write went wrong");

  ram_only_a: assert property (
    selWriteRamOnly |=> $stable(nvSel_reg))
    else $error("RAM-only write touched the persistent copy");

  power_reload_a: assert property (
    powerRestore && !selWr |=> ramSel_reg == $past(nvSel_reg))
    else $error("power restore did not reload the live copy");

  read_sel_a: assert property (
    regRd && regAddr == swmd_pkg::OFS_MUX_INPUT && rdIndex_reg == swmd_pkg::IDX_ALL_RAM
      |=> regRdData == swmd_pkg::DATA_W'($past(ramSel_reg[0])))
    else $error("selection read back from the wrong copy");

  unpack_mux_a: assert property (
    srcIsMux |-> unpackedBits == $past(muxWord))
    else $error("unpacked bits do not match the packed word");

  unpack_zero_a: assert property (
    unpackWordSourceSelect_reg == swmd_pkg::SRC_ZERO |=> unpackedBits == '0)
    else $error("zero source did not clear the unpacked bits");

  fb_route_a: assert property (
    txRoute_reg[swmd_pkg::ROUTE_FIELDBUS_BIT] |=> fieldbusInWord == $past(muxWord))
    else $error("fieldbus transmit word is not the packed word");

  tx_idle_a: assert property (
    !txRoute_reg[swmd_pkg::ROUTE_SYSBUS_BIT] |=> sysBusTxWord == '0)
    else $error("unrouted system bus word is not idle");

  rd_index_range_a: assert property (
    rdIndex_reg <= swmd_pkg::IDX_MAX)
    else $error("read index left its range");

  ram_single_a: assert property (
    selWr && wrIndex_reg == swmd_pkg::IDX_RAM_BASE |=> ramSel_reg[0] == $past(newSel))
    else $error("single live slot write went wrong");

  read_nv_a: assert property (
    regRd && regAddr == swmd_pkg::OFS_MUX_INPUT && rdIndex_reg == swmd_pkg::IDX_ALL_NV
      |=> regRdData == swmd_pkg::DATA_W'($past(nvSel_reg[0])))
    else $error("index 0 read did not show the first persistent slot");

  src_legal_a: assert property (
    srcValid(unpackWordSourceSelect_reg))
    else $error("demultiplexer source select holds an unlisted code");

  unpack_rx_a: assert property (
    unpackWordSourceSelect_reg == swmd_pkg::SRC_RXPDO_FIRST |=> unpackedBits == $past(rxWords.rxPdo[0]))
    else $error("unpacked bits do not follow the first received word");

endmodule // swmd_top
`default_nettype wire

// *** swmd_peer_model.sv ***
// peer inverter model: drives received process data words, echoes our transmit word
`timescale 1ns/1ps
`default_nettype none
module swmd_peer_model (
  input  wire logic                                ref_clk,
  input  wire logic                                rst,
  input  wire logic [swmd_pkg::WORD_W-1:0]         txWord,
  output var  swmd_pkg::swmd_rx_s                  rxWords
);
  logic [swmd_pkg::WORD_W-1:0] echoReg;

  // system bus peer sends back what it received one cycle later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      echoReg <= 16'h0000;
    end else begin
      echoReg <= txWord;
    end
  end

  // fixed words on every other source so a wrong selection shows
  always_comb begin
    for (int i = 0; i < swmd_pkg::NUM_RXPDO; i++) begin
      rxWords.rxPdo[i] = 16'h1100 + 16'(i);
    end
    rxWords.rxPdo[0] = echoReg;
    rxWords.remoteCtrl = 16'h2e40;
    rxWords.remoteState = 16'h2e50;
    for (int j = 0; j < swmd_pkg::NUM_FB_OUT; j++) begin
      rxWords.fieldbusOutWord[j] = 16'h5a00 + 16'(j);
    end
    rxWords.ctrlStatus = 16'h3c96;
  end
endmodule // swmd_peer_model
`default_nettype wire

// *** swmd_top_tb.sv ***
// self-checking testbench for the signal word mux/demux block
`timescale 1ns/1ps
`default_nettype none
module swmd_top_tb;
  logic                        ref_clk;
  logic                        rst;
  logic [7:0]                  regAddr;
  logic [31:0]                 regWrData;
  logic                        regWr;
  logic                        regRd;
  logic [31:0]                 regRdData;
  logic                        powerRestore;
  logic [1023:0]               logicSignals;
  swmd_pkg::swmd_rx_s          rxWords;
  logic [15:0]                 muxWord;
  logic [15:0]                 sysBusTxWord;
  logic [15:0]                 fieldbusInWord;
  logic [15:0]                 unpackedBits;
  int                          n_errors;
  int                          total_checks;
  logic [31:0]                 rdv;
  logic [9:0]                  codes [9];
  localparam logic [15:0]      PAT = 16'hc3a5;

  swmd_top u_dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .powerRestore(powerRestore),
    .logicSignals(logicSignals), .rxWords(rxWords), .muxWord(muxWord),
    .sysBusTxWord(sysBusTxWord), .fieldbusInWord(fieldbusInWord), .unpackedBits(unpackedBits));
  swmd_peer_model u_peer (.ref_clk(ref_clk), .rst(rst), .txWord(sysBusTxWord), .rxWords(rxWords));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    d = regRdData;
  endtask

  // selection -> mux word -> routed words need two edges; one spare
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  task automatic pulse_restore();
    @(posedge ref_clk);
    powerRestore <= 1'b1;
    @(posedge ref_clk);
    powerRestore <= 1'b0;
    settle();
  endtask

  task automatic t_reset_vals();
    rd(swmd_pkg::OFS_WR_INDEX, rdv); chk("wrIndex", rdv, 32'h1);
    rd(swmd_pkg::OFS_RD_INDEX, rdv); chk("rdIndex", rdv, 32'h1);
    chk("muxWord", {16'h0, muxWord}, 32'h0);
    wr(swmd_pkg::OFS_WR_INDEX, 32'h22);
    rd(swmd_pkg::OFS_WR_INDEX, rdv); chk("wrIndexRange", rdv, 32'h1);
    wr(swmd_pkg::OFS_RD_INDEX, 32'h22);
    rd(swmd_pkg::OFS_RD_INDEX, rdv); chk("rdIndexRange", rdv, 32'h1);
  endtask

  task automatic t_index_all();
    wr(swmd_pkg::OFS_WR_INDEX, 32'h0);
    wr(swmd_pkg::OFS_MUX_INPUT, 32'hc8);
    settle();
    chk("muxAll", {16'h0, muxWord}, 32'hffff);
    wr(swmd_pkg::OFS_RD_INDEX, 32'h10);
    rd(swmd_pkg::OFS_MUX_INPUT, rdv); chk("nvSlot16", rdv, 32'hc8);
    wr(swmd_pkg::OFS_RD_INDEX, 32'h21);
    rd(swmd_pkg::OFS_MUX_INPUT, rdv); chk("ramSlot16", rdv, 32'hc8);
  endtask

  // each input n picks signal 100+n; pattern shows bit placement
  task automatic t_per_slot();
    for (int n = 1; n <= 16; n++) begin
      wr(swmd_pkg::OFS_WR_INDEX, 32'(n));
      wr(swmd_pkg::OFS_MUX_INPUT, 32'(100 + n));
    end
    settle();
    chk("muxSlots", {16'h0, muxWord}, 32'hc3a5);
    rd(swmd_pkg::OFS_MUX_WORD, rdv); chk("muxWordReg", rdv, 32'hc3a5);
    pulse_restore();
    chk("muxAfterRestore", {16'h0, muxWord}, 32'hc3a5);
  endtask

  task automatic t_ram_only();
    // off source clears bit 0, which the pattern has set
    wr(swmd_pkg::OFS_WR_INDEX, 32'h12);
    wr(swmd_pkg::OFS_MUX_INPUT, 32'h7);
    settle();
    chk("ramSlot1", {16'h0, muxWord}, 32'hc3a4);
    wr(swmd_pkg::OFS_RD_INDEX, 32'h1);
    rd(swmd_pkg::OFS_MUX_INPUT, rdv); chk("nvSlot1Kept", rdv, 32'd101);
    wr(swmd_pkg::OFS_RD_INDEX, 32'h0);
    rd(swmd_pkg::OFS_MUX_INPUT, rdv); chk("rdIndexZero", rdv, 32'd101);
    wr(swmd_pkg::OFS_WR_INDEX, 32'h11);
    wr(swmd_pkg::OFS_MUX_INPUT, 32'h9);
    settle();
    chk("ramAllZero", {16'h0, muxWord}, 32'h0);
    pulse_restore();
    chk("reloaded", {16'h0, muxWord}, 32'hc3a5);
    wr(swmd_pkg::OFS_RD_INDEX, 32'h11);
    rd(swmd_pkg::OFS_MUX_INPUT, rdv); chk("ramSlot1Back", rdv, 32'd101);
    rd(8'h40, rdv); chk("unmapped", rdv, 32'h0);
  endtask

  task automatic t_route();
    chk("sysOff", {16'h0, sysBusTxWord}, 32'h0);
    wr(swmd_pkg::OFS_TX_ROUTE, 32'h1);
    settle();
    chk("sysTx", {16'h0, sysBusTxWord}, 32'hc3a5);
    chk("fbOff", {16'h0, fieldbusInWord}, 32'h0);
    wr(swmd_pkg::OFS_TX_ROUTE, 32'h3);
    settle();
    chk("fbIn", {16'h0, fieldbusInWord}, 32'hc3a5);
  endtask

  function automatic logic [15:0] src_exp(input logic [9:0] c);
    case (c)
      swmd_pkg::SRC_ZERO:         return 16'h0000;
      swmd_pkg::SRC_RXPDO_LAST:   return 16'h1117;
      swmd_pkg::SRC_REMOTE_CTRL:  return 16'h2e40;
      swmd_pkg::SRC_REMOTE_STATE: return 16'h2e50;
      swmd_pkg::SRC_FB_OUT_FIRST: return 16'h5a00;
      swmd_pkg::SRC_FB_OUT_LAST:  return 16'h5a03;
      swmd_pkg::SRC_CTRL_STATUS:  return 16'h3c96;
      default:                    return 16'hc3a5;
    endcase
  endfunction

  task automatic t_unpack();
    codes = '{10'h009, 10'h2c0, 10'h2d7, 10'h2e4, 10'h2e5, 10'h2f2, 10'h2f5, 10'h384, 10'h39f};
    for (int i = 0; i < 9; i++) begin
      wr(swmd_pkg::OFS_UNPACK_SRC, {22'h0, codes[i]});
      settle();
      chk("unpacked", {16'h0, unpackedBits}, {16'h0, src_exp(codes[i])});
    end
    wr(swmd_pkg::OFS_UNPACK_SRC, 32'h8);
    rd(swmd_pkg::OFS_UNPACK_SRC, rdv); chk("srcRefused", rdv, 32'h39f);
    rd(swmd_pkg::OFS_UNPACK_WORD, rdv); chk("unpackWordReg", rdv, 32'hc3a5);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    complete_run();
  end

  initial begin
    n_errors = 0;
    total_checks = 0;
    rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    powerRestore = 1'b0;
    logicSignals = '0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    // bit 7 is the off source and must stay low
    for (int n = 1; n <= 16; n++) begin
      logicSignals[100 + n] <= PAT[n - 1];
    end
    logicSignals[200] <= 1'b1;
    t_reset_vals();
    t_index_all();
    t_per_slot();
    t_ram_only();
    t_route();
    t_unpack();
    complete_run();
  end
endmodule // swmd_top_tb
`default_nettype wire
